// ==== logic/sdcke_power_ctl.sv ====
// sdram clock-enable command handling: self-refresh, power-down, suspend
// Behaviour
// - clock enable falling with refresh pins and all banks idle enters self-refresh
// - self-refresh ends on clock enable rising with deselect or no-operation pins
// - falling clock enable with no access runs that command, then power-down
// - falling clock enable during access suspends internal clock from next cycle
// - masks are ignored on clock-enable command cycles, address only on the rising one
// - read access ends one cycle after the last data-out cycle
// - write access ends two cycles after the last data-in cycle
// - activate takes row from address bits 0-11, bank from 12-13
// - column address width follows organisation, bits 0-7 for x16
// - 4096 refresh commands cover all banks within 64 ms
// - bursts are serial or interleaved, length 1, 2, 4, 8 or page
// - data masked per cycle, two lane masks only for x16
// - everything is sampled on the single system clock
// - deselected pins are ignored, running bursts continue
// - auto-deactivate bit high closes the bank once the access ends, after its end-of-access tail
`timescale 1ns/10ps
module sdcke_power_ctl
  import sdcke_pkg::*;
#(
  parameter int COL_W = 8,
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr_pins,
  input wire logic [LANES-1:0] upper_lower_lane_mask,
  // mode settings
  input wire logic [2:0] burst_len_code,
  input wire logic burst_interleave,
  input wire logic [1:0] read_latency,
  // power state
  output logic int_clk_en,
  output logic self_refresh,
  output logic power_down,
  output logic clock_suspend,
  output logic access_busy,
  // bank and burst state
  output logic [NUM_BANKS-1:0] bank_open_q,
  output logic [ROW_W-1:0] act_row_q,
  output logic [BANK_W-1:0] act_bank_q,
  output logic [COL_W-1:0] burst_col_q,
  output logic burst_valid_q,
  output logic [LANES-1:0] data_mask_q,
  // refresh
  output logic [REF_ROW_W-1:0] refresh_row_q,
  output logic self_ref_tick_q
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // pin decode

  sdcke_state_t st_q, st_d;
  logic cke_prev_q;
  logic [TAIL_W-1:0] tail_q;
  logic wr_q;
  logic ap_q;
  logic [BANK_W-1:0] ap_bank_q;
  logic busy_prev_q;
  logic [REF_DIV_W-1:0] ref_div_q;

  sdcke_burst_if #(.COL_W(COL_W)) bif ();

  wire [2:0] cmd_pins = {ras_n, cas_n, we_n};
  wire [BANK_W-1:0] bank_sel = addr_pins[BANK_LSB +: BANK_W];
  wire clk_run = (st_q == ST_RUN);
  wire cke_fall = cke_prev_q && !cke;
  wire cke_cmd_cyc = (cke_prev_q != cke);
  wire cmd_en = clk_run && cke_prev_q && !cs_n;
  wire all_idle = ~|bank_open_q;
  wire busy = bif.busy || (tail_q != '0);
  wire sref_pins = !cs_n && (cmd_pins == CMD_REF);
  wire exit_ok = cke && (cs_n || (cmd_pins == CMD_NOP));
  wire is_act = cmd_en && (cmd_pins == CMD_ACT);
  wire is_rd = cmd_en && (cmd_pins == CMD_READ);
  wire is_wr = cmd_en && (cmd_pins == CMD_WRITE);
  wire is_pre = cmd_en && (cmd_pins == CMD_PRE);
  // refresh with clock enable low is self-refresh entry, not auto-refresh
  wire is_ref = cmd_en && cke && (cmd_pins == CMD_REF);
  wire close_ap = ap_q && busy_prev_q && !busy;
  wire [TAIL_W-1:0] rd_tail = TAIL_W'(read_latency + RD_TAIL_EXTRA - 1);
  wire [TAIL_W-1:0] wr_tail = TAIL_W'(WR_TAIL_CYC - 1);
  wire ref_step_done = (ref_div_q == REF_DIV_W'(REF_STEP_CYC - 1));

  assign int_clk_en = clk_run;
  assign self_refresh = (st_q == ST_SREF);
  assign power_down = (st_q == ST_PDOWN);
  assign clock_suspend = (st_q == ST_SUSP);
  assign access_busy = busy;

  ////////////////////////////////////////////////////////////////////////
  // clock-enable state machine

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RUN: begin
        if (cke_fall) begin
          if (sref_pins && all_idle) st_d = ST_SREF;
          else if (busy) st_d = ST_SUSP;
          else st_d = ST_PDOWN;
        end
      end
      ST_SREF: if (exit_ok) st_d = ST_RUN;
      ST_PDOWN: if (cke) st_d = ST_RUN;
      ST_SUSP: if (cke) st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= ST_RUN;
      cke_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cke_prev_q <= cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst and end-of-access tracking

  assign bif.start = is_rd || is_wr;
  assign bif.il = burst_interleave;
  assign bif.len = burst_len_code;
  assign bif.col0 = addr_pins[COL_W-1:0];
  assign bif.hold = !clk_run;

  sdcke_burst_seq u_seq (
    .core_clk(core_clk),
    .resetn(resetn),
    .bif(bif.seq)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tail_q <= '0;
      wr_q <= 1'b0;
    end else if (bif.start) begin
      tail_q <= '0;
      wr_q <= is_wr;
    end else if (clk_run && bif.last) begin
      tail_q <= wr_q ? wr_tail : rd_tail;
    end else if (clk_run && tail_q != '0) begin
      tail_q <= TAIL_W'(tail_q - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ap_q <= 1'b0;
      ap_bank_q <= '0;
      busy_prev_q <= 1'b0;
    end else begin
      busy_prev_q <= busy;
      if (bif.start) begin
        ap_q <= addr_pins[AUTO_DEACT_BIT];
        ap_bank_q <= bank_sel;
      end else if (close_ap) begin
        ap_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank open state

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire hit = (bank_sel == BANK_W'(b));
    wire pre_hit = is_pre && (addr_pins[AUTO_DEACT_BIT] || hit);
    wire ap_hit = close_ap && (ap_bank_q == BANK_W'(b));
    always_ff @(posedge core_clk) begin
      if (!resetn) bank_open_q[b] <= 1'b0;
      else if (is_act && hit) bank_open_q[b] <= 1'b1;
      else if (pre_hit || ap_hit) bank_open_q[b] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // captured fields, masks and refresh

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      act_row_q <= '0;
      act_bank_q <= '0;
    end else if (is_act) begin
      act_row_q <= addr_pins[ROW_LSB +: ROW_W];
      act_bank_q <= bank_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      burst_col_q <= '0;
      burst_valid_q <= 1'b0;
      data_mask_q <= '0;
    end else begin
      if (clk_run) begin
        burst_col_q <= bif.col;
        burst_valid_q <= bif.busy;
      end
      if (clk_run && !cke_cmd_cyc) data_mask_q <= upper_lower_lane_mask;
    end
  end

  // self-refresh paces rows so 4096 fit in the window
  always_ff @(posedge core_clk) begin
    if (!resetn || st_q != ST_SREF) begin
      ref_div_q <= '0;
    end else begin
      ref_div_q <= ref_step_done ? '0 : REF_DIV_W'(ref_div_q + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      refresh_row_q <= '0;
      self_ref_tick_q <= 1'b0;
    end else begin
      self_ref_tick_q <= self_refresh && ref_step_done;
      if (is_ref || (self_refresh && ref_step_done))
        refresh_row_q <= REF_ROW_W'(refresh_row_q + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_sref_entry;
    clk_run && cke_fall && sref_pins && all_idle |=> self_refresh && !int_clk_en;
  endproperty
  a_sref_entry: assert property (p_sref_entry)
    else $error("self-refresh entry missed");

  property p_sref_exit;
    self_refresh |-> (if (exit_ok) ##1 clk_run else ##1 self_refresh);
  endproperty
  a_sref_exit: assert property (p_sref_exit)
    else $error("self-refresh exit wrong");

  property p_pdown;
    (clk_run && cke_fall && !busy && !(sref_pins && all_idle) |=> power_down && !int_clk_en)
      and (power_down && cke |=> clk_run);
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power-down entry or exit wrong");

  property p_suspend;
    clk_run && cke_fall && busy && !(sref_pins && all_idle)
      |=> clock_suspend && !int_clk_en;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("clock suspend not entered");

  property p_mask_ignored;
    clk_run && cke_cmd_cyc |=> data_mask_q == $past(data_mask_q);
  endproperty
  a_mask_ignored: assert property (p_mask_ignored)
    else $error("mask taken on clock-enable command cycle");

  property p_read_tail;
    clk_run && bif.last && !wr_q && !bif.start |=> tail_q == rd_tail && busy;
  endproperty
  a_read_tail: assert property (p_read_tail)
    else $error("read access end wrong");

  property p_write_tail;
    clk_run && bif.last && wr_q && !bif.start ##1 clk_run && !bif.start
      |=> !busy;
  endproperty
  a_write_tail: assert property (p_write_tail)
    else $error("write access not over two cycles after last data");

  property p_act_fields;
    is_act |=> act_row_q == $past(addr_pins[ROW_LSB +: ROW_W])
      && bank_open_q[$past(bank_sel)];
  endproperty
  a_act_fields: assert property (p_act_fields)
    else $error("activate fields not captured");

  property p_refresh_count;
    is_ref |=> refresh_row_q == REF_ROW_W'($past(refresh_row_q) + 1'b1);
  endproperty
  a_refresh_count: assert property (p_refresh_count)
    else $error("refresh row did not advance");

  property p_deselect;
    cs_n |-> !bif.start && !is_act && !is_ref;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("command taken while deselected");

endmodule : sdcke_power_ctl

// ==== shared/sdcke_pkg.sv ====
// constants and types for the sdram clock-enable power control block
package sdcke_pkg;

  // clock and refresh timing
  localparam int CLK_MHZ = 40;
  localparam int REF_WINDOW_MS = 64;
  localparam int REF_CMDS = 4096;
  // longest spacing, so rounded down
  localparam int REF_STEP_CYC = REF_WINDOW_MS * 1000 * CLK_MHZ / REF_CMDS;
  localparam int REF_DIV_W = $clog2(REF_STEP_CYC);
  localparam int REF_ROW_W = $clog2(REF_CMDS);

  // address fields
  localparam int ROW_LSB = 0;
  localparam int ROW_W = 12;
  localparam int BANK_LSB = 12;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 14;
  localparam int AUTO_DEACT_BIT = 10;

  // end-of-access tails, in cycles after the last data cycle
  localparam int WR_TAIL_CYC = 2;
  localparam int RD_TAIL_EXTRA = 1;
  localparam int TAIL_W = 3;

  // burst length codes
  localparam logic [2:0] BL_PAGE = 3'h7;

  // command pins {row strobe, column strobe, write enable}, active low
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SUSP = 2'h1,
    ST_PDOWN = 2'h2,
    ST_SREF = 2'h3
  } sdcke_state_t;

endpackage : sdcke_pkg

// ==== shared/sdcke_burst_if.sv ====
// burst sequencer hookup between command logic and column counter
`timescale 1ns/10ps
interface sdcke_burst_if #(
  parameter int COL_W = 8
);
  logic start;
  logic il;
  logic [2:0] len;
  logic [COL_W-1:0] col0;
  logic hold;
  logic [COL_W-1:0] col;
  logic busy;
  logic last;

  modport ctl (output start, il, len, col0, hold, input col, busy, last);
  modport seq (input start, il, len, col0, hold, output col, busy, last);
endinterface : sdcke_burst_if

// ==== logic/sdcke_burst_seq.sv ====
// burst column sequencer, serial or interleaved, freezable
`timescale 1ns/10ps
module sdcke_burst_seq
  import sdcke_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command side
  sdcke_burst_if.seq bif
);
  localparam int CW = $bits(bif.col);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic [CW-1:0] base_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask_q;
  logic il_q;
  logic busy_q;
  wire [CW-1:0] len_mask;
  wire [CW-1:0] offs;

  // wrap stays inside the burst-length block
  assign len_mask = (bif.len == BL_PAGE) ? '1 : CW'((32'h1 << bif.len) - 32'h1);
  assign offs = il_q ? (base_q ^ cnt_q) : CW'(base_q + cnt_q);
  assign bif.col = (base_q & ~mask_q) | (offs & mask_q);
  assign bif.busy = busy_q;
  assign bif.last = busy_q && (cnt_q == mask_q);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      base_q <= '0;
      cnt_q <= '0;
      mask_q <= '0;
      il_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (bif.start && !bif.hold) begin
      base_q <= bif.col0;
      cnt_q <= '0;
      mask_q <= len_mask;
      il_q <= bif.il;
      busy_q <= 1'b1;
    end else if (busy_q && !bif.hold) begin
      cnt_q <= CW'(cnt_q + 1'b1);
      busy_q <= !bif.last;
    end
  end

  property p_hold_freeze;
    bif.hold && busy_q && !bif.start |=> busy_q && $stable(cnt_q) && $stable(bif.col);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("burst moved while suspended");

  property p_serial_step;
    busy_q && !il_q && !bif.hold && !bif.last && !bif.start
      |=> (bif.col & mask_q) == (($past(bif.col) + 1'b1) & mask_q);
  endproperty
  a_serial_step: assert property (p_serial_step)
    else $error("serial burst column did not step by one");

endmodule : sdcke_burst_seq

// ==== testbench/sdcke_ctl_model.sv ====
// controller model driving the sdram command and clock-enable pins
`timescale 1ns/10ps
module sdcke_ctl_model
  import sdcke_pkg::*;
(
  // clock and status
  input wire logic core_clk,
  input wire logic access_busy,
  // pins
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [ADDR_W-1:0] addr,
  output logic [1:0] mask
);
  logic wr_q = 1'b0;

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = CMD_NOP;
    addr = '0;
    mask = '0;
  end

  // change after the falling edge, hold to the next
  task automatic issue(input logic k, input logic s, input logic [2:0] c,
    input logic [13:0] a, input logic [1:0] dm);
    cke = k;
    cs_n = s;
    cmd = c;
    addr = a;
    mask = dm;
    if (!s && (c == CMD_WRITE || c == CMD_READ)) begin
      wr_q = (c == CMD_WRITE);
    end
    @(negedge core_clk);
  endtask : issue

  // no clock-enable drop behind write data
  task automatic hold_low(input logic [2:0] c, input logic [13:0] a, input logic [1:0] dm);
    while (wr_q && access_busy) begin
      issue(1'b1, 1'b0, CMD_NOP, ~a, dm);
    end
    issue(1'b0, 1'b0, c, a, dm);
  endtask : hold_low

  // enable and select stay low, other pins keep toggling
  task automatic stay_low(input int n);
    repeat (n) begin
      issue(1'b0, 1'b0, ~cmd, ~addr, ~mask);
    end
  endtask : stay_low

  // wake, then a no-operation before anything else
  task automatic wake(input logic s, input logic [2:0] c, input logic [13:0] a);
    issue(1'b1, s, c, a, mask);
    issue(1'b1, 1'b0, CMD_NOP, ~a, mask);
  endtask : wake

  task automatic refresh(input logic [13:0] a);
    issue(1'b1, 1'b0, CMD_PRE, a | 14'h0400, 2'h0);
    issue(1'b1, 1'b0, CMD_REF, ~a, 2'h0);
  endtask : refresh
endmodule : sdcke_ctl_model

// ==== testbench/testbench.sv ====
// self-checking bench for the sdram clock-enable power control block
`timescale 1ns/10ps
module testbench
  import sdcke_pkg::*;
();
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] blc = 3'h0;
  logic il = 1'b0;
  logic [1:0] rl = 2'h1;
  logic cke;
  logic cs_n;
  logic [2:0] cmd;
  logic [ADDR_W-1:0] addr;
  logic [1:0] mask;
  logic int_clk_en;
  logic self_refresh;
  logic power_down;
  logic clock_suspend;
  logic access_busy;
  logic [NUM_BANKS-1:0] bank_open_q;
  logic [ROW_W-1:0] act_row_q;
  logic [BANK_W-1:0] act_bank_q;
  logic [7:0] burst_col_q;
  logic burst_valid_q;
  logic [1:0] data_mask_q;
  logic [REF_ROW_W-1:0] refresh_row_q;
  logic self_ref_tick_q;
  logic [31:0] seed = 32'hE27E8672;
  int failures = 0;
  int total_checks = 0;

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  sdcke_ctl_model ctl (.core_clk(core_clk), .access_busy(access_busy), .cke(cke),
    .cs_n(cs_n), .cmd(cmd), .addr(addr), .mask(mask));

  sdcke_power_ctl #(.COL_W(8), .LANES(2)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .addr_pins(addr), .upper_lower_lane_mask(mask), .burst_len_code(blc),
    .burst_interleave(il), .read_latency(rl), .int_clk_en(int_clk_en),
    .self_refresh(self_refresh), .power_down(power_down), .clock_suspend(clock_suspend),
    .access_busy(access_busy), .bank_open_q(bank_open_q), .act_row_q(act_row_q),
    .act_bank_q(act_bank_q), .burst_col_q(burst_col_q), .burst_valid_q(burst_valid_q),
    .data_mask_q(data_mask_q), .refresh_row_q(refresh_row_q),
    .self_ref_tick_q(self_ref_tick_q));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] ra();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[13:0];
  endfunction : ra

  function automatic int exp_busy(int len, logic wr, int lat);
    return wr ? len + 1 : len + lat;
  endfunction : exp_busy

  function automatic logic [7:0] exp_col(logic [7:0] c0, int len, logic iv, int i);
    logic [7:0] mk;
    mk = 8'(len - 1);
    return iv ? (c0 ^ 8'(i)) : ((c0 & ~mk) | ((c0 + 8'(i)) & mk));
  endfunction : exp_col

  function automatic int ref_step();
    return 64 * 1000 * 40 / 4096;
  endfunction : ref_step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic nop(input int n);
    logic [13:0] v;
    repeat (n) begin
      v = ra();
      ctl.issue(1'b1, v[13], CMD_NOP, ra(), v[1:0]);
    end
  endtask : nop

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // one access; sus freezes it midway instead of checking its shape
  task automatic burst(input logic [2:0] code, input logic wr, input logic sus);
    logic [13:0] a;
    logic [7:0] c;
    logic [7:0] q[$];
    int len;
    int nb;
    int k;
    len = (code == BL_PAGE) ? 256 : (1 << code);
    a = ra();
    blc = code;
    ctl.issue(1'b1, 1'b0, CMD_ACT, a, 2'h0);
    chk(act_row_q, a[11:0], "row");
    chk(act_bank_q, a[13:12], "bank");
    ctl.issue(1'b1, 1'b0, wr ? CMD_WRITE : CMD_READ, a, 2'h0);
    nb = 0;
    k = 0;
    while (k < 400 && (k < 2 || access_busy === 1'b1 || burst_valid_q === 1'b1)) begin
      nb += (access_busy === 1'b1);
      if (burst_valid_q === 1'b1) begin
        q.push_back(burst_col_q);
      end
      if (sus && k == 2) begin
        ctl.hold_low(CMD_NOP, ra(), 2'h0);
        chk(clock_suspend, 1'b1, "suspend");
        ctl.stay_low(1);
        c = burst_col_q;
        ctl.stay_low(2);
        chk(burst_col_q, c, "frozen");
        ctl.wake(1'b0, CMD_NOP, ra());
        chk(access_busy, 1'b1, "resume");
      end
      nop(1);
      k++;
    end
    chk(k < 400, 1'b1, "drain");
    if (!sus) begin
      chk(nb, exp_busy(len, wr, rl), "busy span");
      chk(q.size(), len, "beats");
      foreach (q[i]) begin
        chk(q[i], exp_col(a[7:0], len, il, i), "column");
      end
    end
    nop(2);
    chk(bank_open_q[a[13:12]], !a[10], "auto close");
  endtask : burst

  initial begin
    #(25 * 20000);
    failures++;
    summarize();
  end

  initial begin
    logic [13:0] t;
    logic [11:0] r;
    int n;
    logic [2:0] codes [5];
    codes = '{3'h0, 3'h1, 3'h2, 3'h3, BL_PAGE};
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    nop(2);
    chk(int_clk_en, 1'b1, "run");
    chk(bank_open_q, 4'h0, "banks");
    foreach (codes[j]) begin
      for (int w = 0; w < 2; w++) begin
        t = ra();
        il = t[0] & (codes[j] != BL_PAGE);
        rl = 2'h1 + 2'(t[5:4] % 3);
        burst(codes[j], w[0], 1'b0);
      end
    end
    end_test("bursts");
    il = 1'b0;
    burst(3'h3, 1'b0, 1'b1);
    end_test("suspend");
    ctl.issue(1'b1, 1'b0, CMD_NOP, ra(), 2'h1);
    chk(data_mask_q, 2'h1, "mask");
    r = act_row_q;
    ctl.hold_low(CMD_NOP, ra(), 2'h2);
    chk(power_down, 1'b1, "pd entry");
    chk(int_clk_en, 1'b0, "pd clock");
    ctl.stay_low(3);
    chk(data_mask_q, 2'h1, "mask held");
    ctl.wake(1'b0, CMD_ACT, ra());
    chk(power_down, 1'b0, "pd exit");
    chk(act_row_q, r, "exit ignored");
    end_test("power-down");
    for (int f = 0; f < 2; f++) begin
      r = refresh_row_q;
      ctl.refresh(ra());
      chk(refresh_row_q, 12'(r + 12'h001), "auto refresh");
      ctl.hold_low(CMD_REF, ra(), 2'h0);
      chk(self_refresh, 1'b1, "sr entry");
      chk(bank_open_q, 4'h0, "sr banks");
      if (f == 0) begin
        n = 0;
        repeat (2 * ref_step()) begin
          ctl.stay_low(1);
          n += (self_ref_tick_q === 1'b1);
        end
        chk(n, 2, "ticks");
      end
      ctl.wake(f == 0, CMD_NOP, ra());
      chk(self_refresh, 1'b0, "sr exit");
      chk(int_clk_en, 1'b1, "sr run");
    end
    end_test("self-refresh");
    summarize();
  end
endmodule : testbench
